// ===== logic/light_sensor_pkg.sv
// Overview of operation
// - registers reachable only over two-wire serial bus
// - command write selects target of later transfers
// - command write may issue special function instead
// - type 01 normal; 00 and 10 reserved
// - answer at 0x29 and also 0x28
// - control enable at 0x00, resets 0x00
// - gain and timing setup at 0x01, resets zero
// - filtered limits 0x04-0x07, read-write, reset zero
// - direct limits 0x08-0x0b, read-write, reset zero
// - repeat count filter at 0x0c, resets zero
// - channel counts 0x14-0x17, read-only, reset zero
// - type 11 marks low field special code
// - bits 4:0 carry address or special code
// - codes force, clear filtered, both, direct
package light_sensor_pkg;

  // ----------------------------------------
  // bus addressing and command layout
  // ----------------------------------------
  localparam logic [6:0] PRIMARY_ADDR = 7'h29;
  localparam logic [6:0] SECONDARY_ADDR = 7'h28;
  localparam int CMD_SELECT_BIT = 7;
  localparam int TXN_MSB = 6;
  localparam int TXN_LSB = 5;
  localparam int CODE_MSB = 4;
  localparam logic [1:0] TXN_NORMAL = 2'h1;
  localparam logic [1:0] TXN_SPECIAL = 2'h3;
  localparam logic [4:0] SF_FORCE_INT = 5'h04;
  localparam logic [4:0] SF_CLEAR_FILTERED = 5'h06;
  localparam logic [4:0] SF_CLEAR_BOTH = 5'h07;
  localparam logic [4:0] SF_CLEAR_DIRECT = 5'h0a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_CONTROL_ENABLE = 5'h00;
  localparam logic [4:0] OFF_GAIN_TIMING = 5'h01;
  localparam logic [4:0] OFF_FILT_LOW_LO = 5'h04;
  localparam logic [4:0] OFF_FILT_LOW_HI = 5'h05;
  localparam logic [4:0] OFF_FILT_HIGH_LO = 5'h06;
  localparam logic [4:0] OFF_FILT_HIGH_HI = 5'h07;
  localparam logic [4:0] OFF_DIRECT_LOW_LO = 5'h08;
  localparam logic [4:0] OFF_DIRECT_LOW_HI = 5'h09;
  localparam logic [4:0] OFF_DIRECT_HIGH_LO = 5'h0a;
  localparam logic [4:0] OFF_DIRECT_HIGH_HI = 5'h0b;
  localparam logic [4:0] OFF_REPEAT_FILTER = 5'h0c;
  localparam logic [4:0] OFF_PACKAGE_ID = 5'h11;
  localparam logic [4:0] OFF_PART_ID = 5'h12;
  localparam logic [4:0] OFF_STATUS = 5'h13;
  localparam logic [4:0] OFF_BROADBAND_LO = 5'h14;
  localparam logic [4:0] OFF_BROADBAND_HI = 5'h15;
  localparam logic [4:0] OFF_INFRARED_LO = 5'h16;
  localparam logic [4:0] OFF_INFRARED_HI = 5'h17;
  localparam int RW_LAST = 12;

  // ----------------------------------------
  // status layout and reset values
  // ----------------------------------------
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_FILTERED_BIT = 4;
  localparam int STAT_DIRECT_BIT = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] PTR_RESET = 5'h00;

  typedef struct packed {
    logic [7:0] control_enable;
    logic [7:0] gain_timing_setup;
    logic [15:0] filtered_low_limit;
    logic [15:0] filtered_high_limit;
    logic [15:0] direct_low_limit;
    logic [15:0] direct_high_limit;
    logic [7:0] repeat_count_filter;
  } setup_t;

  typedef struct packed {
    logic [15:0] broadband_channel;
    logic [15:0] infrared_channel;
  } counts_t;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WR_ACK, ST_READ, ST_RD_ACK
  } bus_state_t;

endpackage

// ===== logic/light_sensor_register_access.sv
`timescale 1ns/100ps
module light_sensor_register_access #(
  // identity values are arbitrary
  parameter logic [7:0] PACKAGE_ID = 8'h00,
  parameter logic [7:0] PART_ID = 8'h5a
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic result_load,
  input wire light_sensor_pkg::counts_t counts_in,
  input wire logic filtered_event,
  input wire logic direct_event,
  output light_sensor_pkg::setup_t setup_out,
  output logic filtered_int,
  output logic direct_int,
  output logic result_valid
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  light_sensor_pkg::bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic read_mode, first_byte, from_secondary, master_ack;
  logic addr_hit, load_pulse, wr_strobe, wr_is_cmd;
  logic cmd_normal, cmd_special, data_wr;
  logic [4:0] ptr_reg;
  logic [7:0] rd_now;
  logic [7:0] rw_mem [0:light_sensor_pkg::RW_LAST];
  light_sensor_pkg::counts_t counts_reg;
  logic [4:0] sf_code;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_rw(input logic [4:0] off);
    is_rw = (off <= light_sensor_pkg::OFF_REPEAT_FILTER) &&
            !(off > light_sensor_pkg::OFF_GAIN_TIMING && off < light_sensor_pkg::OFF_FILT_LOW_LO);
  endfunction

  function automatic logic [7:0] read_byte(input logic [4:0] off);
    read_byte = light_sensor_pkg::RESET_BYTE;
    if (is_rw(off)) begin
      read_byte = rw_mem[off[3:0]];
    end else begin
      case (off)
        light_sensor_pkg::OFF_PACKAGE_ID: read_byte = PACKAGE_ID;
        light_sensor_pkg::OFF_PART_ID: read_byte = PART_ID;
        light_sensor_pkg::OFF_STATUS: begin
          read_byte[light_sensor_pkg::STAT_VALID_BIT] = result_valid;
          read_byte[light_sensor_pkg::STAT_FILTERED_BIT] = filtered_int;
          read_byte[light_sensor_pkg::STAT_DIRECT_BIT] = direct_int;
        end
        light_sensor_pkg::OFF_BROADBAND_LO: read_byte = counts_reg.broadband_channel[7:0];
        light_sensor_pkg::OFF_BROADBAND_HI: read_byte = counts_reg.broadband_channel[15:8];
        light_sensor_pkg::OFF_INFRARED_LO: read_byte = counts_reg.infrared_channel[7:0];
        light_sensor_pkg::OFF_INFRARED_HI: read_byte = counts_reg.infrared_channel[15:8];
        default: read_byte = light_sensor_pkg::RESET_BYTE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_seen = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  // open drain: only ever pulls low
  assign sda_o = 1'b0;

  // ----------------------------------------
  // serial bus slave
  // ----------------------------------------
  // the only path to the register map runs through this slave
  assign addr_hit = (rx_shift[7:1] == light_sensor_pkg::PRIMARY_ADDR) ||
                    (rx_shift[7:1] == light_sensor_pkg::SECONDARY_ADDR);
  assign rd_now = read_byte(ptr_reg);
  assign load_pulse = scl_fall && !start_seen && !stop_seen &&
                      ((state == light_sensor_pkg::ST_ADDR_ACK && read_mode) ||
                       (state == light_sensor_pkg::ST_RD_ACK && master_ack));
  assign wr_strobe = scl_fall && !start_seen && !stop_seen &&
                     state == light_sensor_pkg::ST_WRITE &&
                     bit_cnt == light_sensor_pkg::BITS_PER_BYTE;
  // only the first byte with its top bit set is a command
  assign wr_is_cmd = first_byte && rx_shift[light_sensor_pkg::CMD_SELECT_BIT];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= light_sensor_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      sda_oe <= 1'b0;
      read_mode <= 1'b0;
      first_byte <= 1'b0;
      from_secondary <= 1'b0;
      master_ack <= 1'b0;
    end else if (start_seen) begin
      state <= light_sensor_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
      first_byte <= 1'b1;
    end else if (stop_seen) begin
      state <= light_sensor_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        light_sensor_pkg::ST_ADDR: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == light_sensor_pkg::BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (addr_hit) begin
              state <= light_sensor_pkg::ST_ADDR_ACK;
              sda_oe <= 1'b1;
              read_mode <= rx_shift[0];
              from_secondary <= rx_shift[7:1] == light_sensor_pkg::SECONDARY_ADDR;
            end else begin
              state <= light_sensor_pkg::ST_IDLE;
            end
          end
        end
        light_sensor_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_mode) begin
              tx_shift <= rd_now;
              sda_oe <= ~rd_now[7];
              state <= light_sensor_pkg::ST_READ;
            end else begin
              sda_oe <= 1'b0;
              state <= light_sensor_pkg::ST_WRITE;
            end
          end
        end
        light_sensor_pkg::ST_WRITE: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == light_sensor_pkg::BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            sda_oe <= 1'b1;
            first_byte <= 1'b0;
            state <= light_sensor_pkg::ST_WR_ACK;
          end
        end
        light_sensor_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= light_sensor_pkg::ST_WRITE;
          end
        end
        light_sensor_pkg::ST_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == light_sensor_pkg::BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              sda_oe <= 1'b0;
              state <= light_sensor_pkg::ST_RD_ACK;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe <= ~tx_shift[6];
            end
          end
        end
        light_sensor_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s2;
          end else if (scl_fall) begin
            if (master_ack) begin
              tx_shift <= rd_now;
              sda_oe <= ~rd_now[7];
              state <= light_sensor_pkg::ST_READ;
            end else begin
              state <= light_sensor_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= light_sensor_pkg::ST_IDLE;
        end
      endcase
    end
  end

  addr_ack_a: assert property (
    (state == light_sensor_pkg::ST_ADDR && scl_fall && !start_seen && !stop_seen &&
     bit_cnt == light_sensor_pkg::BITS_PER_BYTE && addr_hit)
    |=> sda_oe && state == light_sensor_pkg::ST_ADDR_ACK)
    else $error("address not acknowledged");

  // ----------------------------------------
  // command decode and pointer
  // ----------------------------------------
  assign sf_code = rx_shift[light_sensor_pkg::CODE_MSB:0];
  assign cmd_normal = wr_strobe && wr_is_cmd &&
    rx_shift[light_sensor_pkg::TXN_MSB:light_sensor_pkg::TXN_LSB] ==
    light_sensor_pkg::TXN_NORMAL;
  assign cmd_special = wr_strobe && wr_is_cmd &&
    rx_shift[light_sensor_pkg::TXN_MSB:light_sensor_pkg::TXN_LSB] ==
    light_sensor_pkg::TXN_SPECIAL;
  // secondary address is a read path; its data writes are dropped
  assign data_wr = wr_strobe && !wr_is_cmd && !from_secondary;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_reg <= light_sensor_pkg::PTR_RESET;
    end else if (cmd_normal) begin
      ptr_reg <= sf_code;
    end else if (data_wr || load_pulse) begin
      ptr_reg <= ptr_reg + 5'h01;
    end
  end

  sequence s_cmd_normal;
    cmd_normal;
  endsequence
  sequence s_cmd_other;
    wr_strobe && wr_is_cmd && !cmd_normal;
  endsequence

  ptr_select_a: assert property (s_cmd_normal |=> ptr_reg == $past(sf_code))
    else $error("pointer not loaded by command");
  special_keep_a: assert property (s_cmd_other |=> $stable(ptr_reg))
    else $error("special or reserved command moved pointer");
  reserved_type_a: assert property (
    (wr_strobe && wr_is_cmd && rx_shift[6:5] != light_sensor_pkg::TXN_NORMAL &&
     rx_shift[6:5] != light_sensor_pkg::TXN_SPECIAL && !filtered_event && !direct_event)
    |=> $stable(ptr_reg) && $stable(filtered_int) && $stable(direct_int))
    else $error("reserved transaction type acted");

  // ----------------------------------------
  // read-write register file
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi <= light_sensor_pkg::RW_LAST; gi++) begin : g_rw
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          rw_mem[gi] <= light_sensor_pkg::RESET_BYTE;
        end else if (data_wr && is_rw(ptr_reg) && ptr_reg == 5'(gi)) begin
          rw_mem[gi] <= rx_shift;
        end
      end
    end
  endgenerate

  assign setup_out.control_enable = rw_mem[light_sensor_pkg::OFF_CONTROL_ENABLE[3:0]];
  assign setup_out.gain_timing_setup = rw_mem[light_sensor_pkg::OFF_GAIN_TIMING[3:0]];
  assign setup_out.filtered_low_limit = {rw_mem[light_sensor_pkg::OFF_FILT_LOW_HI[3:0]],
                                         rw_mem[light_sensor_pkg::OFF_FILT_LOW_LO[3:0]]};
  assign setup_out.filtered_high_limit = {rw_mem[light_sensor_pkg::OFF_FILT_HIGH_HI[3:0]],
                                          rw_mem[light_sensor_pkg::OFF_FILT_HIGH_LO[3:0]]};
  assign setup_out.direct_low_limit = {rw_mem[light_sensor_pkg::OFF_DIRECT_LOW_HI[3:0]],
                                       rw_mem[light_sensor_pkg::OFF_DIRECT_LOW_LO[3:0]]};
  assign setup_out.direct_high_limit = {rw_mem[light_sensor_pkg::OFF_DIRECT_HIGH_HI[3:0]],
                                        rw_mem[light_sensor_pkg::OFF_DIRECT_HIGH_LO[3:0]]};
  assign setup_out.repeat_count_filter = rw_mem[light_sensor_pkg::OFF_REPEAT_FILTER[3:0]];

  enable_write_a: assert property (
    (data_wr && ptr_reg == light_sensor_pkg::OFF_CONTROL_ENABLE)
    |=> setup_out.control_enable == $past(rx_shift))
    else $error("control enable not written");
  limit_write_a: assert property (
    (data_wr && ptr_reg == light_sensor_pkg::OFF_FILT_HIGH_HI)
    |=> setup_out.filtered_high_limit[15:8] == $past(rx_shift) &&
        $stable(setup_out.filtered_high_limit[7:0]))
    else $error("filtered limit byte misplaced");
  direct_write_a: assert property (
    (data_wr && ptr_reg == light_sensor_pkg::OFF_DIRECT_LOW_LO)
    |=> setup_out.direct_low_limit[7:0] == $past(rx_shift) && $stable(ptr_reg) == 1'b0)
    else $error("direct limit byte misplaced");
  ro_write_a: assert property (
    (data_wr && !is_rw(ptr_reg) && !result_load)
    |=> $stable(setup_out) && $stable(counts_reg))
    else $error("write to read-only offset changed state");

  // ----------------------------------------
  // conversion results and status
  // ----------------------------------------
  // both channels captured together so a pair is never torn
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      counts_reg <= '0;
      result_valid <= 1'b0;
    end else if (result_load) begin
      counts_reg <= counts_in;
      result_valid <= 1'b1;
    end
  end

  // event set wins over a clearing command in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filtered_int <= 1'b0;
    end else if (filtered_event ||
                 (cmd_special && sf_code == light_sensor_pkg::SF_FORCE_INT)) begin
      filtered_int <= 1'b1;
    end else if (cmd_special && (sf_code == light_sensor_pkg::SF_CLEAR_FILTERED ||
                                 sf_code == light_sensor_pkg::SF_CLEAR_BOTH)) begin
      filtered_int <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      direct_int <= 1'b0;
    end else if (direct_event ||
                 (cmd_special && sf_code == light_sensor_pkg::SF_FORCE_INT)) begin
      direct_int <= 1'b1;
    end else if (cmd_special && (sf_code == light_sensor_pkg::SF_CLEAR_DIRECT ||
                                 sf_code == light_sensor_pkg::SF_CLEAR_BOTH)) begin
      direct_int <= 1'b0;
    end
  end

  result_load_a: assert property (result_load |=> counts_reg == $past(counts_in) ##1
    ($past(result_load) || $stable(counts_reg)))
    else $error("conversion counts not captured");
  force_int_a: assert property (
    (cmd_special && sf_code == light_sensor_pkg::SF_FORCE_INT) |=> filtered_int && direct_int)
    else $error("force interrupt did not set flags");
  clear_both_a: assert property (
    (cmd_special && sf_code == light_sensor_pkg::SF_CLEAR_BOTH && !filtered_event &&
     !direct_event) |=> !filtered_int && !direct_int)
    else $error("clear both left a flag set");
  clear_direct_a: assert property (
    (cmd_special && sf_code == light_sensor_pkg::SF_CLEAR_DIRECT && !direct_event)
    |=> !direct_int && filtered_int == $past(filtered_int || filtered_event))
    else $error("direct clear wrong");

endmodule

// ===== verification/serial_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// two-wire bus host, open drain with pull-up
// ----------------------------------------
module serial_host_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl,
  output logic sda
);
  logic sda_drv;

  // released line floats to the pull-up level
  // wired and: the device pulls with its own data level while enabled
  assign sda = sda_drv & (~sda_oe | sda_o);

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // eight cycles a phase keeps well above the four-cycle minimum
  task automatic half();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic start_cond();
    sda_drv = 1'b1;
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
    half();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ===== verification/light_sensor_register_access_test.sv
`timescale 1ns/100ps
module light_sensor_register_access_test;
  // identity values are arbitrary
  localparam logic [7:0] pkg_code = 8'h3c;
  localparam logic [7:0] part_code = 8'hc5;
  logic ref_clk, nrst, scl, sda, sda_o, sda_oe, result_load, filtered_event, direct_event;
  logic filtered_int, direct_int, result_valid;
  light_sensor_pkg::counts_t counts_in;
  light_sensor_pkg::setup_t setup_out;
  logic [7:0] exp_map [0:31];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int miscompares = 0;
  int n_checks = 0;

  light_sensor_register_access #(.PACKAGE_ID(pkg_code), .PART_ID(part_code)) i_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .result_load(result_load),
    .counts_in(counts_in),
    .filtered_event(filtered_event),
    .direct_event(direct_event),
    .setup_out(setup_out),
    .filtered_int(filtered_int),
    .direct_int(direct_int),
    .result_valid(result_valid)
  );

  serial_host_model i_host (.ref_clk(ref_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl),
    .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic exp_ack);
    logic ack;
    i_host.start_cond();
    i_host.wr_byte({a, 1'b0}, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
    if (ack) foreach (wq[i]) i_host.wr_byte(wq[i], ack);
    i_host.stop_cond();
    wq.delete();
  endtask

  task automatic rd(input logic [6:0] a, input int n);
    logic ack;
    logic [7:0] d;
    rq.delete();
    i_host.start_cond();
    i_host.wr_byte({a, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      i_host.rd_byte(d, i == n - 1);
      rq.push_back(d);
    end
    i_host.stop_cond();
  endtask

  // command byte always carries bit 7 and normal type
  task automatic point(input logic [4:0] off);
    wq.push_back({3'b101, off});
    wr(light_sensor_pkg::PRIMARY_ADDR, 1'b1);
  endtask

  task automatic read_map(input logic [4:0] off, input int n);
    point(off);
    rd(light_sensor_pkg::PRIMARY_ADDR, n);
    for (int i = 0; i < n; i++) check(rq[i], exp_map[int'(off) + i]);
  endtask

  task automatic special(input logic [1:0] txn, input logic [4:0] code, input logic f,
                         input logic d);
    wq.push_back({1'b1, txn, code});
    wr(light_sensor_pkg::PRIMARY_ADDR, 1'b1);
    check({7'h00, filtered_int}, {7'h00, f});
    check({7'h00, direct_int}, {7'h00, d});
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    result_load = 1'b0;
    counts_in = '0;
    filtered_event = 1'b0;
    direct_event = 1'b0;
    foreach (exp_map[i]) exp_map[i] = 8'h00;
    exp_map[8'h11] = pkg_code;
    exp_map[8'h12] = part_code;
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    read_map(5'h00, 24);
    // one block over the whole map; read-only and holes keep their values
    wq.push_back(8'ha0);
    for (int i = 0; i < 24; i++) begin
      wq.push_back(8'h40 + 8'(i));
      if (i < 2 || (i > 3 && i < 13)) exp_map[i] = 8'h40 + 8'(i);
    end
    wr(light_sensor_pkg::PRIMARY_ADDR, 1'b1);
    check(setup_out.control_enable, exp_map[0]);
    check(setup_out.gain_timing_setup, exp_map[1]);
    check(setup_out.filtered_high_limit[15:8], exp_map[7]);
    check(setup_out.direct_low_limit[7:0], exp_map[8]);
    check(setup_out.repeat_count_filter, exp_map[12]);
    read_map(5'h00, 24);
    // secondary address drops data but serves reads
    wq.push_back(8'ha0);
    wq.push_back(8'hff);
    wr(light_sensor_pkg::SECONDARY_ADDR, 1'b1);
    check(setup_out.control_enable, exp_map[0]);
    point(5'h11);
    rd(light_sensor_pkg::SECONDARY_ADDR, 2);
    check(rq[0], pkg_code);
    check(rq[1], part_code);
    wr(7'h30, 1'b0);
    // conversion result, channel 0 first, low byte first
    counts_in = {16'hb2a1, 16'hd4c3};
    result_load = 1'b1;
    @(posedge ref_clk);
    #1;
    result_load = 1'b0;
    exp_map[8'h13] = 8'h01;
    exp_map[8'h14] = 8'ha1;
    exp_map[8'h15] = 8'hb2;
    exp_map[8'h16] = 8'hc3;
    exp_map[8'h17] = 8'hd4;
    read_map(5'h13, 5);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_FORCE_INT, 1, 1);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_CLEAR_FILTERED, 0, 1);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_CLEAR_DIRECT, 0, 0);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_FORCE_INT, 1, 1);
    special(light_sensor_pkg::TXN_SPECIAL, 5'h01, 1, 1);
    special(2'h0, light_sensor_pkg::SF_CLEAR_BOTH, 1, 1);
    special(2'h2, light_sensor_pkg::SF_CLEAR_BOTH, 1, 1);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_CLEAR_BOTH, 0, 0);
    // flags raised by the conversion core show in status
    filtered_event = 1'b1;
    direct_event = 1'b1;
    @(posedge ref_clk);
    #1;
    filtered_event = 1'b0;
    direct_event = 1'b0;
    exp_map[8'h13] = 8'h31;
    read_map(5'h13, 1);
    special(light_sensor_pkg::TXN_SPECIAL, light_sensor_pkg::SF_CLEAR_BOTH, 0, 0);
    wrap_up();
  end

  // the full sequence needs roughly thirty thousand cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
endmodule
